// *** rsir_status_regs.sv ***
// Behaviour
// RQ1: bit 7 of the fault register goes to 1 once current limiting is entered or left.
// RQ2: bit 8 of the fault register reads 1 after an adapter-side overvoltage fault.
// RQ3: bit 9 of the fault register reads 1 after an over-temperature fault.
// RQ4: bit 10 of the fault register reads 1 after an output undervoltage fault.
// RQ5: bit 11 of the fault register reads 1 after an output overvoltage fault.
// RQ6: bit 12 of the fault register reads 1 after a way-overcurrent fault.
// RQ7: bits 14:13 of the fault register give the active control loop.
// RQ8: bit 15 of the fault register is 1 while the reference is active.
// RQ9: bits 4:0 of the mode register give the programming-resistor code.
// RQ10: bits 7:5 of the mode register give the conversion mode.
// RQ11: bits 11:8 of the mode register give the state-machine state.
// RQ12: bit 14 of the mode register is 1 while forward switching is enabled.
// RQ13: unused bits read 0 and host writes change nothing.
`timescale 1ns/10ps
`default_nettype none

module rsir_status_regs (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   // serial link
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // regulator status sources
   input  wire logic        cur_limit_active,
   input  wire logic        adapter_side_overvoltage,
   input  wire logic        over_temp_fault,
   input  wire logic        output_undervoltage_fault,
   input  wire logic        output_overvoltage_fault,
   input  wire logic        way_overcurrent_fault,
   input  wire logic [1:0]  active_loop,
   input  wire logic        ref_active,
   input  wire logic [4:0]  prog_code,
   input  wire logic [2:0]  conv_mode,
   input  wire logic [3:0]  sm_state,
   input  wire logic        fwd_switch_en,
   // register images
   output logic [15:0]      fault_status_r,
   output logic [15:0]      mode_status_r
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   rsir_pkg::rsir_state_t         st_r;
   rsir_pkg::rsir_state_t         ack_src_r;
   logic                          scl_rise;
   logic                          scl_fall;
   logic                          start_det;
   logic                          stop_det;
   logic [7:0]                    sh_r;
   logic [7:0]                    cmd_r;
   logic [7:0]                    tx_r;
   logic [3:0]                    cnt_r;
   logic                          rd_r;
   logic                          byte_sel_r;
   logic                          nack_r;
   logic [15:0]                   snap_r;
   logic [15:0]                   sel_word;
   logic                          cl_prev_r;
   logic                          load_snap;
   logic [rsir_pkg::FS_STICKY_N-1:0] ev;
   logic [rsir_pkg::FS_STICKY_N-1:0] clr;
   logic [rsir_pkg::FS_STICKY_N-1:0] sticky_nxt;

   rsir_line_events u_line (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // ----------------------------------------------------------------
   // status capture
   // ----------------------------------------------------------------
   assign ev = {way_overcurrent_fault, output_overvoltage_fault,
                output_undervoltage_fault, over_temp_fault,
                adapter_side_overvoltage,
                cur_limit_active ^ cl_prev_r}; // see RQ1

   // reading the fault word clears what it reported; a new event wins
   assign clr = load_snap ? fault_status_r[rsir_pkg::FS_WOC_BIT:
                                           rsir_pkg::FS_CUR_LIMIT_BIT]
                          : '0;

   genvar gi;
   generate
      for (gi = 0; gi < rsir_pkg::FS_STICKY_N; gi++) begin : g_sticky
         assign sticky_nxt[gi] = ev[gi] |
            (fault_status_r[rsir_pkg::FS_CUR_LIMIT_BIT + gi] & ~clr[gi]);
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cl_prev_r <= 1'b0;
      end else if (clk_en) begin
         cl_prev_r <= cur_limit_active;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_status_r <= 16'h0000;
      end else if (clk_en) begin
         fault_status_r <= {ref_active,                    // see RQ8
                            active_loop,                   // see RQ7
                            sticky_nxt,  // see RQ2 RQ3 RQ4 RQ5 RQ6
                            7'h00};                        // see RQ13
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_status_r <= 16'h0000;
      end else if (clk_en) begin
         mode_status_r <= {1'b0,
                           fwd_switch_en,                  // see RQ12
                           2'h0,                           // see RQ13
                           sm_state,                       // see RQ11
                           conv_mode,                      // see RQ10
                           prog_code};                     // see RQ9
      end
   end

   // ----------------------------------------------------------------
   // serial slave
   // ----------------------------------------------------------------
   always_comb begin
      case (cmd_r)
         rsir_pkg::FAULT_LOOP_OFF: sel_word = fault_status_r;
         rsir_pkg::MODE_STATE_OFF: sel_word = mode_status_r;
         default:                  sel_word = rsir_pkg::UNMAPPED_VAL;
      endcase
   end

   assign load_snap = clk_en & ~start_det & ~stop_det & scl_fall &
                      (st_r == rsir_pkg::ST_ACK) &
                      (ack_src_r == rsir_pkg::ST_ADDR) & rd_r &
                      (cmd_r == rsir_pkg::FAULT_LOOP_OFF);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_out <= 1'b0;
      end else if (clk_en) begin
         sda_out <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r       <= rsir_pkg::ST_IDLE;
         ack_src_r  <= rsir_pkg::ST_IDLE;
         sh_r       <= 8'h00;
         cmd_r      <= 8'h00;
         tx_r       <= 8'h00;
         cnt_r      <= 4'h0;
         rd_r       <= 1'b0;
         byte_sel_r <= 1'b0;
         nack_r     <= 1'b0;
         snap_r     <= 16'h0000;
         sda_oe     <= 1'b0;
      end else if (clk_en) begin
         if (stop_det) begin
            st_r   <= rsir_pkg::ST_IDLE;
            sda_oe <= 1'b0;
         end else if (start_det) begin
            st_r   <= rsir_pkg::ST_ADDR;
            cnt_r  <= 4'h0;
            sda_oe <= 1'b0;
         end else begin
            case (st_r)
               rsir_pkg::ST_ADDR,
               rsir_pkg::ST_CMD,
               rsir_pkg::ST_WDAT: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda_in};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall &&
                               cnt_r == rsir_pkg::BITS_PER_BYTE) begin
                     cnt_r     <= 4'h0;
                     ack_src_r <= st_r;
                     if (st_r != rsir_pkg::ST_ADDR ||
                         sh_r[7:1] == rsir_pkg::SLAVE_ADDR) begin
                        st_r   <= rsir_pkg::ST_ACK;
                        sda_oe <= 1'b1;
                     end else begin
                        st_r <= rsir_pkg::ST_IDLE;
                     end
                     if (st_r == rsir_pkg::ST_ADDR) begin
                        rd_r <= sh_r[0];
                     end
                     if (st_r == rsir_pkg::ST_CMD) begin
                        cmd_r <= sh_r;
                     end
                  end
               end
               rsir_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     case (ack_src_r)
                        rsir_pkg::ST_ADDR: begin
                           if (rd_r) begin
                              // whole word frozen so both bytes agree
                              snap_r     <= sel_word;
                              tx_r       <= sel_word[7:0];
                              byte_sel_r <= 1'b0;
                              sda_oe     <= ~sel_word[7];
                              st_r       <= rsir_pkg::ST_TX;
                           end else begin
                              sda_oe <= 1'b0;
                              st_r   <= rsir_pkg::ST_CMD;
                           end
                        end
                        default: begin
                           // written data is acked and dropped
                           sda_oe <= 1'b0;
                           st_r   <= rsir_pkg::ST_WDAT;    // see RQ13
                        end
                     endcase
                  end
               end
               rsir_pkg::ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_r == rsir_pkg::LAST_TX_BIT) begin
                        cnt_r  <= 4'h0;
                        sda_oe <= 1'b0;
                        st_r   <= rsir_pkg::ST_RACK;
                     end else begin
                        cnt_r  <= cnt_r + 4'h1;
                        tx_r   <= {tx_r[6:0], 1'b0};
                        sda_oe <= ~tx_r[6];
                     end
                  end
               end
               rsir_pkg::ST_RACK: begin
                  if (scl_rise) begin
                     nack_r <= sda_in;
                  end else if (scl_fall) begin
                     if (nack_r) begin
                        st_r <= rsir_pkg::ST_IDLE;
                     end else begin
                        // word repeats low, high, low... until nack
                        byte_sel_r <= ~byte_sel_r;
                        tx_r   <= byte_sel_r ? snap_r[7:0] : snap_r[15:8];
                        sda_oe <= byte_sel_r ? ~snap_r[7] : ~snap_r[15];
                        st_r   <= rsir_pkg::ST_TX;
                     end
                  end
               end
               rsir_pkg::ST_IDLE: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  st_r   <= rsir_pkg::ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_adp_event;
      clk_en && adapter_side_overvoltage;
   endsequence

   sequence s_no_clear;
      clk_en && !load_snap && !adapter_side_overvoltage;
   endsequence

   a_cur_limit_edge: assert property ( // see RQ1
      (clk_en && (cur_limit_active != cl_prev_r))
      |=> fault_status_r[rsir_pkg::FS_CUR_LIMIT_BIT])
      else $error("current limit edge not flagged");

   a_adp_ov_hold: assert property ( // see RQ2
      s_adp_event ##1 s_no_clear [*3]
      |=> fault_status_r[rsir_pkg::FS_ADP_OV_BIT])
      else $error("adapter overvoltage flag not held");

   a_otp_flag: assert property ( // see RQ3
      (clk_en && over_temp_fault) |=> fault_status_r[rsir_pkg::FS_OTP_BIT])
      else $error("over-temperature flag missing");

   a_uv_flag: assert property ( // see RQ4
      (clk_en && !load_snap && !output_undervoltage_fault &&
       !fault_status_r[rsir_pkg::FS_UV_BIT])
      |=> !fault_status_r[rsir_pkg::FS_UV_BIT])
      else $error("undervoltage flag set without cause");

   a_ov_woc_flag: assert property ( // see RQ5 RQ6
      (clk_en && output_overvoltage_fault && way_overcurrent_fault)
      |=> fault_status_r[rsir_pkg::FS_WOC_BIT:rsir_pkg::FS_OV_BIT] == 2'h3)
      else $error("overvoltage or overcurrent flag missing");

   a_loop_ref_live: assert property ( // see RQ7 RQ8
      clk_en |=> fault_status_r[rsir_pkg::FS_REF_BIT:rsir_pkg::FS_LOOP_LSB]
                 == $past({ref_active, active_loop}))
      else $error("loop or reference field stale");

   a_mode_word_live: assert property ( // see RQ9 RQ10 RQ11 RQ12
      clk_en |=> mode_status_r == $past({1'b0, fwd_switch_en, 2'h0,
                                         sm_state, conv_mode, prog_code}))
      else $error("mode and state word stale");

   a_unused_zero: assert property ( // see RQ13
      fault_status_r[6:0] == 7'h00 && mode_status_r[15] == 1'b0 &&
      mode_status_r[13:12] == 2'h0)
      else $error("unused status bit not zero");

   // write data must never clear a reported fault flag
   a_write_no_effect: assert property ( // see RQ13
      (clk_en && st_r == rsir_pkg::ST_WDAT)
      |=> fault_status_r[rsir_pkg::FS_WOC_BIT:rsir_pkg::FS_CUR_LIMIT_BIT]
          == $past(fault_status_r[rsir_pkg::FS_WOC_BIT:
                                  rsir_pkg::FS_CUR_LIMIT_BIT] | ev))
      else $error("host write disturbed fault flags");

endmodule // rsir_status_regs

`default_nettype wire

// *** rsir_pkg.sv ***
package rsir_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  FAULT_LOOP_OFF = 8'h3A;
   localparam logic [7:0]  MODE_STATE_OFF = 8'h4D;
   localparam logic [15:0] UNMAPPED_VAL   = 16'h0000;

   // ----------------------------------------------------------------
   // fault_and_loop_status fields
   // ----------------------------------------------------------------
   localparam int FS_CUR_LIMIT_BIT = 7;
   localparam int FS_ADP_OV_BIT    = 8;
   localparam int FS_OTP_BIT       = 9;
   localparam int FS_UV_BIT        = 10;
   localparam int FS_OV_BIT        = 11;
   localparam int FS_WOC_BIT       = 12;
   localparam int FS_STICKY_N      = 6;
   localparam int FS_LOOP_LSB      = 13;
   localparam int FS_LOOP_MSB      = 14;
   localparam int FS_REF_BIT       = 15;

   localparam logic [1:0] LOOP_VOLTAGE   = 2'h0;
   localparam logic [1:0] LOOP_SYS_CUR   = 2'h1;
   localparam logic [1:0] LOOP_ADP_CUR   = 2'h2;
   localparam logic [1:0] LOOP_INPUT_VLT = 2'h3;

   // ----------------------------------------------------------------
   // mode_and_state_status fields
   // ----------------------------------------------------------------
   localparam int MS_PROG_LSB  = 0;
   localparam int MS_PROG_MSB  = 4;
   localparam int MS_MODE_LSB  = 5;
   localparam int MS_MODE_MSB  = 7;
   localparam int MS_STATE_LSB = 8;
   localparam int MS_STATE_MSB = 11;
   localparam int MS_FWD_BIT   = 14;

   localparam logic [2:0] MODE_FWD_BOOST = 3'h1;
   localparam logic [2:0] MODE_FWD_BUCK  = 3'h2;
   localparam logic [2:0] MODE_FWD_BB    = 3'h3;
   localparam logic [2:0] MODE_REV_BOOST = 3'h5;
   localparam logic [2:0] MODE_REV_BUCK  = 3'h6;
   localparam logic [2:0] MODE_REV_BB    = 3'h7;

   localparam logic [3:0] SM_RESET               = 4'h0;
   localparam logic [3:0] SM_REVERSE_SUPPLY_RDY  = 4'h1;
   localparam logic [3:0] SM_FORWARD_RUN_MODE    = 4'h5;
   localparam logic [3:0] SM_REVERSE_SUPPLY_MODE = 4'h7;
   localparam logic [3:0] SM_FORWARD_READY_STATE = 4'hA;

   // ----------------------------------------------------------------
   // serial link
   // ----------------------------------------------------------------
   // slave address value is arbitrary
   localparam logic [6:0] SLAVE_ADDR = 7'h2C;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK  = 3'h3,
      ST_CMD  = 3'h2,
      ST_WDAT = 3'h6,
      ST_TX   = 3'h7,
      ST_RACK = 3'h5
   } rsir_state_t;

endpackage

// *** rsir_line_events.sv ***
`timescale 1ns/10ps
`default_nettype none

module rsir_line_events (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic clk_en,
   // link lines
   input  wire logic scl_in,
   input  wire logic sda_in,
   // line events
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det
);

   logic scl_q_r;
   logic sda_q_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else if (clk_en) begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   assign scl_rise  = scl_in & ~scl_q_r;
   assign scl_fall  = ~scl_in & scl_q_r;
   // sda moving while scl stays high frames a transfer
   assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
   assign stop_det  = scl_in & scl_q_r & ~sda_q_r & sda_in;

endmodule // rsir_line_events

`default_nettype wire

// *** rsir_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module rsir_host_model (
   // clock
   input  wire logic        core_clk,
   // link lines
   input  wire logic        sda_line,
   output logic             scl,
   output logic             host_oe,
   // result report
   output logic             res_valid,
   output logic [15:0]      res_data
);
   // ----------------------------------------------------------------
   // bit timing: 3 cycles per quarter, no clock stretching
   // ----------------------------------------------------------------
   localparam int QTR = 3;

   initial begin
      scl       = 1'b1;
      host_oe   = 1'b0;
      res_valid = 1'b0;
      res_data  = 16'h0000;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // data moves only while scl is low, sampled in the middle of the high phase
   task automatic bit_io(input logic b, output logic got);
      scl <= 1'b0;
      wait_clk(QTR);
      host_oe <= ~b;
      wait_clk(QTR);
      scl <= 1'b1;
      wait_clk(QTR);
      got = sda_line;
      wait_clk(QTR);
   endtask

   task automatic byte_out(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], g);
      end
      bit_io(1'b1, g);
      ack = ~g;
   endtask

   task automatic byte_in(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(last, g);
   endtask

   task automatic start_cond(input logic again);
      if (again) begin
         scl <= 1'b0;
         wait_clk(QTR);
         host_oe <= 1'b0;
         wait_clk(QTR);
         scl <= 1'b1;
         wait_clk(2 * QTR);
      end
      host_oe <= 1'b1;
      wait_clk(2 * QTR);
   endtask

   task automatic stop_cond;
      scl <= 1'b0;
      wait_clk(QTR);
      host_oe <= 1'b1;
      wait_clk(QTR);
      scl <= 1'b1;
      wait_clk(2 * QTR);
      host_oe <= 1'b0;
      wait_clk(2 * QTR);
   endtask

   task automatic report(input logic [15:0] d);
      res_data  <= d;
      res_valid <= 1'b1;
      wait_clk(1);
      res_valid <= 1'b0;
   endtask

   task automatic read_word(input logic [6:0] dev, input logic [7:0] cmd);
      logic       a;
      logic [7:0] lo;
      logic [7:0] hi;
      start_cond(1'b0);
      byte_out({dev, 1'b0}, a);
      byte_out(cmd, a);
      start_cond(1'b1);
      byte_out({dev, 1'b1}, a);
      byte_in(1'b0, lo);
      byte_in(1'b1, hi);
      stop_cond();
      report({hi, lo});
   endtask

   // reports the acks: address, command, both data bytes
   task automatic write_word(input logic [6:0] dev, input logic [7:0] cmd,
                             input logic [15:0] d);
      logic [3:0] a;
      start_cond(1'b0);
      byte_out({dev, 1'b0}, a[3]);
      byte_out(cmd, a[2]);
      byte_out(d[7:0], a[1]);
      byte_out(d[15:8], a[0]);
      stop_cond();
      report({13'h0000, a[3], a[2], a[1] & a[0]});
   endtask
endmodule // rsir_host_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic        core_clk;
   logic        rst_b;
   logic        clk_en;
   logic        scl;
   logic        host_oe;
   logic        sda_out;
   logic        sda_oe;
   logic        cur_limit_active;
   logic [4:0]  flt;
   logic [1:0]  active_loop;
   logic        ref_active;
   logic [4:0]  prog_code;
   logic [2:0]  conv_mode;
   logic [3:0]  sm_state;
   logic        fwd_switch_en;
   logic [15:0] fault_status_r;
   logic [15:0] mode_status_r;
   logic        res_valid;
   logic [15:0] res_data;
   wire         sda_line;
   logic [15:0] exp_q[$];
   logic [5:0]  sticky;
   logic [31:0] rng;
   logic [15:0] hold;
   int          mismatches;
   int          checked;

   // pull-up on the data line; open drain from both parties
   assign sda_line = ~host_oe & (sda_oe ? sda_out : 1'b1);

   rsir_status_regs i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .cur_limit_active(cur_limit_active),
      .adapter_side_overvoltage(flt[0]), .over_temp_fault(flt[1]),
      .output_undervoltage_fault(flt[2]), .output_overvoltage_fault(flt[3]),
      .way_overcurrent_fault(flt[4]), .active_loop(active_loop),
      .ref_active(ref_active), .prog_code(prog_code), .conv_mode(conv_mode),
      .sm_state(sm_state), .fwd_switch_en(fwd_switch_en),
      .fault_status_r(fault_status_r), .mode_status_r(mode_status_r));

   rsir_host_model i_host (
      .core_clk(core_clk), .sda_line(sda_line), .scl(scl),
      .host_oe(host_oe), .res_valid(res_valid), .res_data(res_data));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction

   function automatic logic [15:0] exp_fault();
      return {ref_active, active_loop, sticky, 7'h00};
   endfunction

   function automatic logic [15:0] exp_mode();
      return {1'b0, fwd_switch_en, 2'h0, sm_state, conv_mode, prog_code};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish;
      if (exp_q.size() != 0) mismatches++;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // result watcher
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (res_valid === 1'b1) begin
         if (exp_q.size() == 0) mismatches++;
         else check(res_data, exp_q.pop_front());
      end
   end

   initial begin
      wait_clk(40000);
      mismatches++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      logic [2:0] modes[6];
      logic [3:0] states[5];
      modes  = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
      states = '{4'h0, 4'h1, 4'h5, 4'h7, 4'hA};
      rng = 32'h00002387; // seed 9095
      rst_b = 1'b0;
      clk_en = 1'b1;
      cur_limit_active = 1'b0;
      flt = 5'h00;
      active_loop = 2'h0;
      ref_active = 1'b0;
      prog_code = 5'h00;
      conv_mode = 3'h0;
      sm_state = 4'h0;
      fwd_switch_en = 1'b0;
      sticky = 6'h00;
      mismatches = 0;
      checked = 0;
      wait_clk(16);
      rst_b <= 1'b1;
      wait_clk(3);
      check(fault_status_r, 16'h0000);
      check(mode_status_r, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         conv_mode     <= modes[i];
         sm_state      <= states[i % 5];
         active_loop   <= 2'(i);
         prog_code     <= rng[4:0];
         fwd_switch_en <= rng[5];
         ref_active    <= rng[6];
         wait_clk(3);
         check(fault_status_r, exp_fault());
         check(mode_status_r, exp_mode());
         exp_q.push_back(exp_mode());
         i_host.read_word(rsir_pkg::SLAVE_ADDR, rsir_pkg::MODE_STATE_OFF);
      end
      // each fault is a one-cycle pulse; the flag must outlive it
      for (int i = 0; i < 5; i++) begin
         flt[i] <= 1'b1;
         wait_clk(1);
         flt[i] <= 1'b0;
         sticky[i+1] = 1'b1;
         wait_clk(3);
         check(fault_status_r, exp_fault());
      end
      cur_limit_active <= 1'b1;
      sticky[0] = 1'b1;
      wait_clk(3);
      check(fault_status_r, exp_fault());
      exp_q.push_back(exp_fault());
      i_host.read_word(rsir_pkg::SLAVE_ADDR, rsir_pkg::FAULT_LOOP_OFF);
      sticky = 6'h00;
      wait_clk(3);
      check(fault_status_r, exp_fault());
      cur_limit_active <= 1'b0;
      sticky[0] = 1'b1;
      wait_clk(3);
      exp_q.push_back(exp_fault());
      i_host.read_word(rsir_pkg::SLAVE_ADDR, rsir_pkg::FAULT_LOOP_OFF);
      sticky = 6'h00;
      // writes to the slave address are acknowledged but change nothing
      hold = mode_status_r;
      exp_q.push_back(16'h0007);
      i_host.write_word(rsir_pkg::SLAVE_ADDR, rsir_pkg::FAULT_LOOP_OFF,
                        16'hFFFF);
      exp_q.push_back(16'h0007);
      i_host.write_word(rsir_pkg::SLAVE_ADDR, rsir_pkg::MODE_STATE_OFF,
                        16'hFFFF);
      wait_clk(3);
      check(fault_status_r, exp_fault());
      check(mode_status_r, hold);
      exp_q.push_back(16'h0000);
      i_host.write_word(rsir_pkg::SLAVE_ADDR ^ 7'h01,
                        rsir_pkg::FAULT_LOOP_OFF, 16'h0000);
      exp_q.push_back(16'h0000);
      i_host.read_word(rsir_pkg::SLAVE_ADDR, 8'h00);
      // clock enable low freezes the images
      hold = fault_status_r;
      clk_en <= 1'b0;
      ref_active <= ~ref_active;
      wait_clk(3);
      check(fault_status_r, hold);
      clk_en <= 1'b1;
      wait_clk(3);
      check(fault_status_r, exp_fault());
      wait_clk(4);
      tally_and_finish();
   end
endmodule // tb_top

`default_nettype wire
